/* core/dops_pkg.sv */
// Purpose: Shared constants and types for the dual output PWM steering block
// Assumes: One 50 MHz clock, synchronous active-low reset
// Notes: Control levels are expressed in ramp counts, not volts
package dops_pkg;
  // Clock rate
  localparam int CLK_HZ = 50_000_000;
  // Ramp and control level width
  localparam int RAMP_W = 16;
  localparam int THR_W = RAMP_W + 1;
  // Shortest usable ramp period in counts
  localparam logic [RAMP_W-1:0] PERIOD_MIN = 16'h0002;
  // Built-in dead-time offset as a share of the ramp cycle
  localparam int DT_MIN_PCT = 4;
  localparam int PCT_FULL = 100;
  // Reset values
  localparam logic [RAMP_W-1:0] RAMP_RST = 16'h0000;
  localparam logic STEER_RST = 1'b0;
  localparam logic DRIVE_RST = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h0;

  // Output mode, as selected by the mode pin
  typedef enum logic {
    DOPS_SINGLE = 1'b0,
    DOPS_PUSH_PULL = 1'b1
  } dops_mode_e;

  // Least dead time in counts, rounded up, never below one count
  function automatic logic [RAMP_W-1:0] dops_dead_min(input logic [RAMP_W-1:0] period);
    logic [31:0] prod;
    prod = (32'(period) * 32'(DT_MIN_PCT) + 32'(PCT_FULL - 1)) / 32'(PCT_FULL);
    if (prod == 32'h0) begin
      prod = 32'h1;
    end
    return prod[RAMP_W-1:0];
  endfunction
endpackage

/* core/dops_if.sv */
// Purpose: Carrier between the ramp counter and the modulator core
// Assumes: Both ends on the same clock
// Notes: Period flows to the ramp, ramp value and cycle start flow back
`timescale 1ns/100ps
interface dops_if;
  import dops_pkg::*;
  logic [RAMP_W-1:0] period; // Programmed ramp period in counts
  logic [RAMP_W-1:0] ramp; // Current sawtooth value
  logic cycle_start; // High while the ramp sits at zero (discharge)

  // Ramp generator end
  modport src (
    input period,
    output ramp,
    output cycle_start
  );

  // Modulator end
  modport use_side (
    output period,
    input ramp,
    input cycle_start
  );
endinterface

/* core/dops_ramp.sv */
// Purpose: Free-running sawtooth counter with programmable period
// Assumes: Period comes from logic on the same clock
// Notes: A period below the minimum is treated as the minimum
`timescale 1ns/100ps
module dops_ramp
  import dops_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  dops_if.src ramp_if
);
  logic [RAMP_W-1:0] ramp; // Counter value
  logic [RAMP_W-1:0] next_ramp; // Next counter value
  logic [RAMP_W-1:0] last; // Top count of this period

  // Next ramp value, wraps at the top count
  always_comb begin
    if (ramp_if.period < PERIOD_MIN) begin
      last = PERIOD_MIN - 16'h0001;
    end else begin
      last = ramp_if.period - 16'h0001;
    end
    if (ramp >= last) begin
      // Wrap also catches a period shortened below the current value
      next_ramp = RAMP_RST;
    end else begin
      next_ramp = ramp + 16'h0001;
    end
  end

  // Ramp register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ramp <= RAMP_RST;
    end else begin
      ramp <= next_ramp;
    end
  end

  assign ramp_if.ramp = ramp;
  assign ramp_if.cycle_start = (ramp == RAMP_RST);

  // Ramp always returns to zero after the top count
  a_ramp_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ramp >= last && ramp_if.period == $past(ramp_if.period)) |=> ramp == RAMP_RST)
    else $error("Ramp did not wrap at the top count");
endmodule

/* core/dops_top.sv */
// Purpose: Fixed-frequency PWM with dead-time and feedback compares and pulse steering
// Assumes: Levels and period come from logic on clk_i; the mode pin is asynchronous
// Notes: Outputs are registered, one clock behind the ramp compare
`timescale 1ns/100ps

// Notes on behaviour
// - Drives pass only while ramp exceeds levels
// - Higher control level gives linearly shorter pulse
// - Ramp compared with dead-time and feedback levels
// - Feedback inputs ORed, shortest on-time wins
// - Built-in dead time of first 4 percent
// - Duty limit 96 single, 48 push-pull
// - Dead-time level adds extra dead time
// - Single-ended: both drives same pulse each cycle
// - Push-pull: pulses alternate, half frequency
// - Discharge toggles steering in push-pull, forces drives off
// - Feedback range sweeps on-time to zero
// - Push-pull never pulses one output twice
module dops_top
  import dops_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [RAMP_W-1:0] period_i,
  input wire logic [RAMP_W-1:0] dead_level_i,
  input wire logic [RAMP_W-1:0] fb_a_i,
  input wire logic [RAMP_W-1:0] fb_b_i,
  input wire logic output_mode_i,
  output logic first_output_drive_o,
  output logic second_output_drive_o
);
  // Link to the ramp counter
  dops_if ramp_if ();

  // Ramp generator
  dops_ramp u_ramp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ramp_if(ramp_if)
  );

  assign ramp_if.period = period_i;

  // Mode pin synchroniser, bit 0 is the first stage
  logic [2:0] mode_sync;
  logic [2:0] next_mode_sync;
  // Mode in force for the current ramp cycle
  dops_mode_e mode;
  dops_mode_e next_mode;

  // Shift the pin in; adopt a new mode only at a cycle start
  always_comb begin
    next_mode_sync = {mode_sync[1:0], output_mode_i};
    next_mode = mode;
    // Switching mid-cycle could hand one output two pulses in a row
    if (ramp_if.cycle_start && (mode_sync[1] == mode_sync[2])) begin
      next_mode = dops_mode_e'(mode_sync[2]);
    end
  end

  // Mode registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_sync <= SYNC_RST;
      mode <= DOPS_SINGLE;
    end else begin
      mode_sync <= next_mode_sync;
      mode <= next_mode;
    end
  end

  // Compare thresholds in ramp counts, one bit wider to avoid overflow
  logic [RAMP_W-1:0] dead_min; // Built-in dead time
  logic [THR_W-1:0] dead_thr; // Dead-time comparator threshold
  logic [THR_W-1:0] fb_thr; // ORed feedback level
  logic [THR_W-1:0] thr; // Governing threshold
  logic pulse; // Ramp above every control level

  // Threshold and compare
  always_comb begin
    // Offset fixes a minimum dead window even with zero dead-time level
    dead_min = dops_dead_min(period_i);
    dead_thr = {1'b0, dead_level_i} + {1'b0, dead_min};
    // The larger feedback level asks for less on-time, so it wins
    if (fb_a_i >= fb_b_i) begin
      fb_thr = {1'b0, fb_a_i};
    end else begin
      fb_thr = {1'b0, fb_b_i};
    end
    // Whichever level is higher governs the pulse
    if (dead_thr >= fb_thr) begin
      thr = dead_thr;
    end else begin
      thr = fb_thr;
    end
    // On-time is the part of the ramp above the threshold
    pulse = ({1'b0, ramp_if.ramp} > thr);
  end

  // Steering flip-flop
  logic steer; // Low selects the first output
  logic next_steer;

  // Toggle on each discharge; held clear in single-ended mode
  always_comb begin
    if (mode != DOPS_PUSH_PULL) begin
      next_steer = STEER_RST;
    end else if (ramp_if.cycle_start) begin
      next_steer = ~steer;
    end else begin
      next_steer = steer;
    end
  end

  // Steering register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      steer <= STEER_RST;
    end else begin
      steer <= next_steer;
    end
  end

  // Output drive values
  logic next_drv1;
  logic next_drv2;

  // Gate the pulse to the outputs; discharge keeps both off
  always_comb begin
    next_drv1 = DRIVE_RST;
    next_drv2 = DRIVE_RST;
    if (ramp_if.cycle_start) begin
      // Discharge window, both outputs inhibited
      next_drv1 = DRIVE_RST;
      next_drv2 = DRIVE_RST;
    end else if (mode == DOPS_SINGLE) begin
      // Same pulse on both outputs every cycle, 96 percent ceiling
      next_drv1 = pulse;
      next_drv2 = pulse;
    end else begin
      // One output per cycle, so each stays under 48 percent
      next_drv1 = pulse & ~steer;
      next_drv2 = pulse & steer;
    end
  end

  // Output registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      first_output_drive_o <= DRIVE_RST;
      second_output_drive_o <= DRIVE_RST;
    end else begin
      first_output_drive_o <= next_drv1;
      second_output_drive_o <= next_drv2;
    end
  end

  // Helper for checking: which output pulsed last in push-pull
  logic last_was_first;
  logic next_last_was_first;

  // Remember the most recent output to pulse
  always_comb begin
    next_last_was_first = last_was_first;
    if (mode != DOPS_PUSH_PULL) begin
      // Steering restarts on the first output, so single-ended history is void
      next_last_was_first = 1'b0;
    end else if (next_drv1 && !first_output_drive_o) begin
      next_last_was_first = 1'b1;
    end else if (next_drv2 && !second_output_drive_o) begin
      next_last_was_first = 1'b0;
    end
  end

  // Helper register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_was_first <= 1'b0;
    end else begin
      last_was_first <= next_last_was_first;
    end
  end

  // Drives stay low while the ramp is at or below the governing level
  a_below_level_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ({1'b0, ramp_if.ramp} <= thr) |=> !first_output_drive_o && !second_output_drive_o)
    else $error("Drive active with ramp not above the control level");

  // Built-in dead window holds the drives off
  a_dead_min_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ramp_if.ramp < dops_dead_min(period_i))
    |=> !first_output_drive_o && !second_output_drive_o)
    else $error("Drive active inside the minimum dead time");

  // Dead-time level alone also forces the drives off
  a_dead_level_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ramp_if.ramp <= dead_level_i) |=> !first_output_drive_o && !second_output_drive_o)
    else $error("Drive active below the dead-time level");

  // Larger feedback level governs
  a_fb_or_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ramp_if.ramp <= fb_a_i || ramp_if.ramp <= fb_b_i)
    |=> !first_output_drive_o && !second_output_drive_o)
    else $error("Drive active below a feedback level");

  // Single-ended: both drives follow the compare
  a_single_both_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == DOPS_SINGLE && pulse && !ramp_if.cycle_start)
    |=> first_output_drive_o && second_output_drive_o)
    else $error("Single-ended drives did not both pulse");

  // Push-pull: never both drives at once
  a_pp_exclusive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == DOPS_PUSH_PULL) |=> !(first_output_drive_o && second_output_drive_o))
    else $error("Both drives active in push-pull");

  // Discharge toggles the steering flop
  a_steer_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == DOPS_PUSH_PULL && ramp_if.cycle_start) |=> steer != $past(steer))
    else $error("Steering did not toggle on discharge");

  // First output never pulsed twice in a row in push-pull
  a_no_double_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == DOPS_PUSH_PULL && $rose(first_output_drive_o)) |-> !$past(last_was_first))
    else $error("First output pulsed twice in a row");

  // Drives and steering come out of reset cleared
  a_reset_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !first_output_drive_o && !second_output_drive_o && !steer)
    else $error("State not cleared by reset");

  // Main scenarios
  c_single_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == DOPS_SINGLE && first_output_drive_o && second_output_drive_o);
  c_pp_first: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == DOPS_PUSH_PULL && $rose(first_output_drive_o));
  c_pp_second: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == DOPS_PUSH_PULL && $rose(second_output_drive_o));
  c_fb_governs: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    fb_thr > dead_thr && pulse);
endmodule

/* tb/dops_stage_model.sv */
// Purpose: Power stage model that loads both drives and tallies their pulses
// Assumes: Drives are active high and sampled on the block clock
// Notes: The clear input restarts tallies but keeps the edge history
`timescale 1ns/100ps
module dops_stage_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic first_output_drive_i,
  input wire logic second_output_drive_i,
  output logic [15:0] on_a_o,
  output logic [15:0] on_b_o,
  output logic [15:0] rise_a_o,
  output logic [15:0] rise_b_o,
  output logic [15:0] overlap_o,
  output logic [15:0] repeat_o
);
  logic prev_a; // Drive levels seen last edge
  logic prev_b;
  logic [1:0] last_side; // 0 none, 1 first, 2 second pulsed last

  // Tally on-cycles, pulse starts, both-on cycles and same-side repeats
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      last_side <= 2'h0;
    end else begin
      prev_a <= first_output_drive_i;
      prev_b <= second_output_drive_i;
      if (first_output_drive_i && !prev_a) begin
        last_side <= 2'h1;
      end else if (second_output_drive_i && !prev_b) begin
        last_side <= 2'h2;
      end
    end
    if (!rst_n_i || clear_i) begin
      // History survives a clear so a pulse straddling it is not a new start
      {on_a_o, on_b_o, rise_a_o, rise_b_o, overlap_o, repeat_o} <= '0;
    end else begin
      on_a_o <= on_a_o + 16'(first_output_drive_i);
      on_b_o <= on_b_o + 16'(second_output_drive_i);
      overlap_o <= overlap_o + 16'(first_output_drive_i && second_output_drive_i);
      if (first_output_drive_i && !prev_a) begin
        rise_a_o <= rise_a_o + 16'h1;
        repeat_o <= repeat_o + 16'(last_side == 2'h1);
      end
      if (second_output_drive_i && !prev_b) begin
        rise_b_o <= rise_b_o + 16'h1;
        repeat_o <= repeat_o + 16'(last_side == 2'h2);
      end
    end
  end
endmodule

/* tb/dual_output_pwm_steering_bench.sv */
// Purpose: Self-checking bench for the PWM steering block
// Assumes: Widths follow the package; ramp period fixed at 100 counts
// Notes: Windows span whole ramp cycles, so alignment does not matter
`timescale 1ns/100ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module dual_output_pwm_steering_bench;
  import dops_pkg::*;
  localparam logic [15:0] P = 16'h0064; // Ramp period, 100 counts
  logic clk_i; // Bench clock, 50 MHz
  logic rst_n_i;
  logic [15:0] period, dead_level, fb_a, fb_b; // Level inputs
  logic output_mode; // Mode pin
  logic drv_a, drv_b; // Drive outputs
  logic clear; // Restarts stage tallies
  logic [15:0] on_a, on_b, rise_a, rise_b, overlap, rpt;
  int bad_count = 0;
  int total_checks = 0;

  dops_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .period_i(period),
    .dead_level_i(dead_level), .fb_a_i(fb_a), .fb_b_i(fb_b), .output_mode_i(output_mode),
    .first_output_drive_o(drv_a), .second_output_drive_o(drv_b));
  dops_stage_model stage (.clk_i(clk_i), .rst_n_i(rst_n_i), .clear_i(clear),
    .first_output_drive_i(drv_a), .second_output_drive_i(drv_b), .on_a_o(on_a),
    .on_b_o(on_b), .rise_a_o(rise_a), .rise_b_o(rise_b), .overlap_o(overlap), .repeat_o(rpt));

  // Free-running clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Compare with case equality, report at once
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  // Single place that ends the run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // On-cycles per ramp cycle: above the larger threshold, ramp 0 excluded
  function automatic logic [15:0] width(input logic [15:0] dl, input logic [15:0] fa,
                                        input logic [15:0] fb);
    logic [16:0] thr;
    thr = 17'(dl) + (17'(P) * 17'h4 + 17'h63) / 17'h64;
    if (17'(fa) > thr) begin
      thr = 17'(fa);
    end
    if (17'(fb) > thr) begin
      thr = 17'(fb);
    end
    if (thr >= 17'(P) - 17'h1) begin
      return 16'h0;
    end
    return 16'(17'(P) - 17'h1 - thr);
  endfunction

  // Apply levels, settle past mode sync and a few cycles, tally two ramp cycles
  task automatic run_case(input logic [15:0] dl, input logic [15:0] fa,
                          input logic [15:0] fb, input logic md);
    logic [15:0] w;
    w = width(dl, fa, fb);
    // Levels change on a rising edge only
    @(posedge clk_i);
    dead_level <= dl;
    fb_a <= fa;
    fb_b <= fb;
    output_mode <= md;
    repeat (4 * P) @(posedge clk_i);
    clear <= 1'b1;
    @(posedge clk_i);
    clear <= 1'b0;
    repeat (2 * P) @(posedge clk_i);
    #1;
    if (md == 1'b0) begin
      `CHK(on_a, 2 * w);
      `CHK(on_b, 2 * w);
      `CHK(overlap, 2 * w);
      `CHK(rise_a, (w == 0) ? 0 : 2);
      `CHK(rise_b, (w == 0) ? 0 : 2);
    end else begin
      `CHK(on_a, w);
      `CHK(on_b, w);
      `CHK(rise_a, (w == 0) ? 0 : 1);
      `CHK(rise_b, (w == 0) ? 0 : 1);
      `CHK(overlap, 0);
      `CHK(rpt, 0);
    end
  endtask

  // Reset holds drives low, first pulse follows the built-in dead time
  task automatic t_reset();
    int n;
    #1;
    `CHK({drv_a, drv_b}, 2'b00);
    // Third edge with reset low, release lands on it
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK({drv_a, drv_b}, 2'b00);
    n = 0;
    while (drv_a !== 1'b1 && n < 2 * P) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 2 * P) begin
      bad_count++;
      conclude();
    end
    // Ramp climbs past four dead counts, then one cycle of latency
    `CHK(n, 5);
    `CHK(drv_b, 1'b1);
    $display("test reset done");
  endtask

  // Single-ended: built-in dead time and added dead time
  task automatic t_single();
    run_case(16'h0000, 16'h0000, 16'h0000, 1'b0);
    run_case(16'h0014, 16'h0000, 16'h0000, 1'b0);
    $display("test single done");
  endtask

  // Feedback levels: larger wins, linear, full range to zero
  task automatic t_feedback();
    run_case(16'h0000, 16'h001E, 16'h0032, 1'b0);
    run_case(16'h0000, 16'h0032, 16'h001E, 1'b0);
    run_case(16'h0000, 16'h003C, 16'h0000, 1'b0);
    run_case(16'h0000, 16'h0063, 16'h0000, 1'b0);
    $display("test feedback done");
  endtask

  // Push-pull alternation, a reset in mid-pulse, then alternation again
  task automatic t_push();
    int n;
    run_case(16'h0000, 16'h0000, 16'h0000, 1'b1);
    run_case(16'h0028, 16'h0000, 16'h0000, 1'b1);
    n = 0;
    while (drv_a !== 1'b1 && drv_b !== 1'b1 && n < 2 * P) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 2 * P) begin
      bad_count++;
      conclude();
    end
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK({drv_a, drv_b}, 2'b00);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK({drv_a, drv_b}, 2'b00);
    // Mode falls back to single in reset and must sync to push-pull again
    run_case(16'h0000, 16'h0000, 16'h0000, 1'b1);
    $display("test push-pull done");
  endtask

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    period = P;
    dead_level = 16'h0000;
    fb_a = 16'h0000;
    fb_b = 16'h0000;
    output_mode = 1'b0;
    clear = 1'b0;
    // Two reset edges here, the third inside t_reset
    repeat (2) @(posedge clk_i);
    t_reset();
    t_single();
    t_feedback();
    t_push();
    conclude();
  end
endmodule
